// File: core/fpr_pkg.sv
// Shared constants and types for the floating-point register bank block.
package fpr_pkg;

	// ----------------------------------------------------------------
	// Storage geometry
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W = 32;
	localparam int unsigned SLOTS  = 16;
	localparam int unsigned VEC_N  = 4;

	// ----------------------------------------------------------------
	// Status/control register layout
	// ----------------------------------------------------------------
	localparam logic [31:0] SC_RESET  = 32'h0004_0001;
	localparam logic [31:0] SC_WMASK  = 32'h003F_FFFF;
	localparam int unsigned BIT_SWAP  = 21;
	localparam int unsigned BIT_PAIR  = 20;
	localparam int unsigned BIT_PREC  = 19;
	localparam int unsigned BIT_DNRM  = 18;
	localparam int unsigned CAUSE_LO  = 12;
	localparam int unsigned ENABLE_LO = 7;
	localparam int unsigned FLAG_LO   = 2;
	localparam int unsigned RND_LO    = 0;
	localparam int unsigned CAUSE_W   = 6;
	localparam int unsigned EXC_W     = 5;

	// Exception bit positions inside a six-bit cause vector.
	localparam int unsigned EXC_E = 5;
	localparam int unsigned EXC_V = 4;
	localparam int unsigned EXC_Z = 3;
	localparam int unsigned EXC_O = 2;
	localparam int unsigned EXC_U = 1;
	localparam int unsigned EXC_I = 0;

	// ----------------------------------------------------------------
	// Number formats
	// ----------------------------------------------------------------
	localparam int unsigned SP_EXP_W  = 8;
	localparam int unsigned SP_FRAC_W = 23;
	localparam int unsigned DP_EXP_W  = 11;
	localparam int unsigned DP_FRAC_W = 52;

	// Rounding selections; the two upper codes are reserved.
	typedef enum logic [1:0] {
		FPR_RND_NEAREST = 2'h0,
		FPR_RND_ZERO    = 2'h1
	} fpr_rnd_t;

endpackage

// File: core/fpr_bank.sv
// Thirty-two word physical register storage, two banks of sixteen slots.
`timescale 1ns/1ns
`default_nettype none

module fpr_bank #(
	parameter int unsigned SLOTS  = 16,
	parameter int unsigned WORD_W = 32
) (
	// Clock.
	input  wire logic                clk_i,
	// Write port; slot is {bank, index}.
	input  wire logic                wr_en_i,
	input  wire logic                wr_pair_i,
	input  wire logic [$clog2(2*SLOTS)-1:0] wr_slot_i,
	input  wire logic [2*WORD_W-1:0] wr_data_i,
	// Every slot, flat, slot k at bits k*WORD_W.
	output logic [2*SLOTS*WORD_W-1:0] slot_o
);

	localparam int unsigned IW = $clog2(2*SLOTS);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] mem_reg [2*SLOTS];

	// Each slot takes a single word at its own index, or one half of an
	// aligned pair; the even slot holds the upper half of the pair.
	for (genvar k = 0; k < 2*SLOTS; k++)
	begin : g_slot
		logic hit_one;
		logic hit_pair;
		assign hit_one  = wr_en_i && !wr_pair_i && wr_slot_i == IW'(k);
		assign hit_pair = wr_en_i && wr_pair_i &&
			wr_slot_i[IW-1:1] == (IW-1)'(k/2);
		always_ff @(posedge clk_i)
		begin
			if (hit_one || (hit_pair && (k % 2) == 1))
				mem_reg[k] <= wr_data_i[WORD_W-1:0];
			else if (hit_pair)
				mem_reg[k] <= wr_data_i[2*WORD_W-1:WORD_W];
		end
		assign slot_o[k*WORD_W +: WORD_W] = mem_reg[k];
	end

endmodule

`default_nettype wire

// File: core/fpr_round.sv
// Final rounding of a normalised intermediate significand.
`timescale 1ns/1ns
`default_nettype none

module fpr_round #(
	parameter int unsigned EXP_W  = 8,
	parameter int unsigned FRAC_W = 23
) (
	// Intermediate value: biased exponent with headroom, 1.f significand.
	input  wire logic                    near_i,
	input  wire logic                    sign_i,
	input  wire logic [EXP_W:0]          exp_i,
	input  wire logic [FRAC_W:0]         sig_i,
	input  wire logic                    guard_i,
	input  wire logic                    sticky_i,
	// Packed result and what rounding found.
	output logic [EXP_W+FRAC_W:0]        result_o,
	output logic                         ovf_o,
	output logic                         inexact_o
);

	localparam logic [EXP_W:0] EXP_TOP = {1'b0, {EXP_W{1'b1}}};

	logic              up;
	logic [FRAC_W+1:0] sum;
	logic [EXP_W:0]    exp_r;
	logic [FRAC_W-1:0] frac_r;

	// A tie goes to the even neighbour; round-to-zero never adds. A carry
	// out of the significand bumps the exponent, which is how a value at or
	// past the top threshold lands on the overflow code.
	always_comb
	begin
		up     = near_i && guard_i && (sticky_i || sig_i[0]);
		sum    = {1'b0, sig_i} + (FRAC_W+2)'(up);
		exp_r  = sum[FRAC_W+1] ? exp_i + (EXP_W+1)'(1) : exp_i;
		frac_r = sum[FRAC_W+1] ? '0 : sum[FRAC_W-1:0];
		ovf_o  = exp_r >= EXP_TOP;
		inexact_o = guard_i || sticky_i || ovf_o;
		if (ovf_o && near_i)
			result_o = {sign_i, EXP_TOP[EXP_W-1:0], {FRAC_W{1'b0}}};
		else if (ovf_o)
			result_o = {sign_i, EXP_TOP[EXP_W-1:1], 1'b0,
				{FRAC_W{1'b1}}};
		else
			result_o = {sign_i, exp_r[EXP_W-1:0], frac_r};
	end

endmodule

`default_nettype wire

// File: core/fpr_core.sv
// Floating-point register bank, status/control and transfer registers.
`timescale 1ns/1ns
`default_nettype none

module fpr_core (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// Status/control load and store.
	input  wire logic         sc_wr_i,
	input  wire logic [31:0]  sc_wdata_i,
	output logic [31:0]       sc_rdata_o,
	// Transfer register load and store.
	input  wire logic         xfer_wr_i,
	input  wire logic [31:0]  xfer_wdata_i,
	output logic [31:0]       xfer_rdata_o,
	// Register moves; back selects the back view.
	input  wire logic         mv_wr_i,
	input  wire logic         mv_wr_back_i,
	input  wire logic [3:0]   mv_wr_idx_i,
	input  wire logic [63:0]  mv_wdata_i,
	input  wire logic         mv_rd_back_i,
	input  wire logic [3:0]   mv_rd_idx_i,
	output logic [63:0]       mv_rdata_o,
	// Vector and matrix views.
	input  wire logic [1:0]   vec_sel_i,
	output logic [127:0]      front_vector_o,
	output logic [511:0]      back_matrix_o,
	// Instruction start and exception report.
	input  wire logic         op_start_i,
	input  wire logic         op_graphics_i,
	input  wire logic         op_exc_valid_i,
	input  wire logic [5:0]   op_exc_i,
	output logic              undefined_o,
	output logic              exc_trap_o,
	// Unrounded arithmetic result.
	input  wire logic         rnd_valid_i,
	input  wire logic [3:0]   rnd_dst_i,
	input  wire logic         rnd_sign_i,
	input  wire logic [11:0]  rnd_exp_i,
	input  wire logic [52:0]  rnd_sig_i,
	input  wire logic         rnd_guard_i,
	input  wire logic         rnd_sticky_i,
	// Current modes for the datapath.
	output logic              prec_o,
	output logic              pair_o,
	output logic              dnrm_o,
	output logic [1:0]        rnd_mode_o
);

	localparam int unsigned W  = fpr_pkg::WORD_W;
	localparam int unsigned N  = fpr_pkg::SLOTS;
	localparam int unsigned CW = fpr_pkg::CAUSE_W;
	localparam int unsigned EW = fpr_pkg::EXC_W;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	// The reset is applied at once but released through two flops.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------------------------------
	// Status/control register
	// ----------------------------------------------------------------
	logic [31:0]   sc_reg;
	logic [31:0]   sc_next;
	logic          swap;
	logic          near;
	logic [CW-1:0] new_exc;
	logic [CW-1:0] cause_base;

	assign swap = sc_reg[fpr_pkg::BIT_SWAP];
	assign near = sc_reg[fpr_pkg::RND_LO +: 2] ==
		fpr_pkg::FPR_RND_NEAREST;

	// A write from software replaces the whole register; an exception in
	// the same cycle is merged on top so a flag is never lost to a clear.
	always_comb
	begin
		sc_next = sc_reg;
		if (sc_wr_i)
			sc_next = sc_wdata_i & fpr_pkg::SC_WMASK;
		cause_base = op_start_i ? '0 :
			sc_next[fpr_pkg::CAUSE_LO +: CW];
		sc_next[fpr_pkg::CAUSE_LO +: CW] = cause_base | new_exc;
		sc_next[fpr_pkg::FLAG_LO +: EW] =
			sc_next[fpr_pkg::FLAG_LO +: EW] | new_exc[EW-1:0];
	end

	// Mode bits change at this edge, so any instruction issued after the
	// write sees the new value and none before it does.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			sc_reg <= fpr_pkg::SC_RESET;
		else
			sc_reg <= sc_next;
	end
	assign sc_rdata_o = sc_reg;
	assign prec_o     = sc_reg[fpr_pkg::BIT_PREC];
	assign pair_o     = sc_reg[fpr_pkg::BIT_PAIR];
	assign dnrm_o     = sc_reg[fpr_pkg::BIT_DNRM];
	assign rnd_mode_o = sc_reg[fpr_pkg::RND_LO +: 2];

	// ----------------------------------------------------------------
	// Transfer register
	// ----------------------------------------------------------------
	logic [31:0] xfer_reg;

	// The core loads and stores this word with system-register moves.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			xfer_reg <= 32'h0000_0000;
		else if (xfer_wr_i)
			xfer_reg <= xfer_wdata_i;
	end
	assign xfer_rdata_o = xfer_reg;

	// ----------------------------------------------------------------
	// Rounding of arithmetic results
	// ----------------------------------------------------------------
	logic [31:0] sp_res;
	logic [63:0] dp_res;
	logic        sp_ovf;
	logic        sp_inx;
	logic        dp_ovf;
	logic        dp_inx;
	logic        sp_sticky;

	// Single precision reuses the top of the double significand; the
	// bits below its round position fold into guard and sticky.
	assign sp_sticky = |rnd_sig_i[27:0] || rnd_guard_i || rnd_sticky_i;

	// Fused results arrive here unrounded, so they are rounded once only.
	fpr_round #(
		.EXP_W  (fpr_pkg::SP_EXP_W),
		.FRAC_W (fpr_pkg::SP_FRAC_W)
	) u_round_sp (
		.near_i    (near),
		.sign_i    (rnd_sign_i),
		.exp_i     (rnd_exp_i[8:0]),
		.sig_i     (rnd_sig_i[52:29]),
		.guard_i   (rnd_sig_i[28]),
		.sticky_i  (sp_sticky),
		.result_o  (sp_res),
		.ovf_o     (sp_ovf),
		.inexact_o (sp_inx)
	);

	fpr_round #(
		.EXP_W  (fpr_pkg::DP_EXP_W),
		.FRAC_W (fpr_pkg::DP_FRAC_W)
	) u_round_dp (
		.near_i    (near),
		.sign_i    (rnd_sign_i),
		.exp_i     (rnd_exp_i),
		.sig_i     (rnd_sig_i),
		.guard_i   (rnd_guard_i),
		.sticky_i  (rnd_sticky_i),
		.result_o  (dp_res),
		.ovf_o     (dp_ovf),
		.inexact_o (dp_inx)
	);

	logic        ovf;
	logic        inx;
	logic        flush;
	logic [63:0] res_word;

	// A zero exponent means a denormal result; with flushing on it is
	// written as a zero of the same sign and counted as underflow.
	always_comb
	begin
		ovf   = prec_o ? dp_ovf : sp_ovf;
		inx   = prec_o ? dp_inx : sp_inx;
		flush = dnrm_o && rnd_exp_i == 12'h000;
		if (flush)
			res_word = prec_o ? {rnd_sign_i, 63'h0} :
				{32'h0000_0000, rnd_sign_i, 31'h0};
		else
			res_word = prec_o ? dp_res : {32'h0000_0000, sp_res};
	end

	// Exceptions seen this cycle, from the datapath and from rounding.
	always_comb
	begin
		new_exc = op_exc_valid_i ? op_exc_i : '0;
		if (rnd_valid_i)
		begin
			new_exc[fpr_pkg::EXC_O] = new_exc[fpr_pkg::EXC_O] || ovf;
			new_exc[fpr_pkg::EXC_U] = new_exc[fpr_pkg::EXC_U] || flush;
			new_exc[fpr_pkg::EXC_I] = new_exc[fpr_pkg::EXC_I] ||
				inx || flush;
		end
	end

	// ----------------------------------------------------------------
	// Bank storage and the write port
	// ----------------------------------------------------------------
	logic [2*N*W-1:0] slots;
	logic             wr_en;
	logic             wr_pair;
	logic [4:0]       wr_slot;
	logic [63:0]      wr_data;

	// An arithmetic result has the port over a move in the same cycle;
	// the move is dropped, as the core never issues both at once.
	always_comb
	begin
		wr_en   = rnd_valid_i || mv_wr_i;
		if (rnd_valid_i)
		begin
			wr_pair = prec_o;
			wr_slot = {swap, rnd_dst_i};
			wr_data = res_word;
		end
		else
		begin
			wr_pair = pair_o;
			wr_slot = {swap ^ mv_wr_back_i, mv_wr_idx_i};
			wr_data = pair_o ? mv_wdata_i :
				{32'h0000_0000, mv_wdata_i[31:0]};
		end
	end

	fpr_bank #(
		.SLOTS  (N),
		.WORD_W (W)
	) u_bank (
		.clk_i     (clk_i),
		.wr_en_i   (wr_en),
		.wr_pair_i (wr_pair),
		.wr_slot_i (wr_slot),
		.wr_data_i (wr_data),
		.slot_o    (slots)
	);

	// ----------------------------------------------------------------
	// Views of the banks
	// ----------------------------------------------------------------
	logic [N*W-1:0] front;
	logic [N*W-1:0] back;
	logic [3:0]     rd_even;
	logic [3:0]     vec_base;

	// The swap bit picks which physical bank each view sees.
	assign front = swap ? slots[2*N*W-1:N*W] : slots[N*W-1:0];
	assign back  = swap ? slots[N*W-1:0] : slots[2*N*W-1:N*W];
	assign rd_even  = {mv_rd_idx_i[3:1], 1'b0};
	assign vec_base = {vec_sel_i, 2'h0};

	logic [63:0]  rd_word;
	logic [127:0] vec_word;
	logic [N*W-1:0] rd_view;

	// A pair read puts the even register in the upper half.
	always_comb
	begin
		rd_view = mv_rd_back_i ? back : front;
		if (pair_o)
			rd_word = {rd_view[rd_even*W +: W],
				rd_view[(rd_even+4'h1)*W +: W]};
		else
			rd_word = {32'h0000_0000, rd_view[mv_rd_idx_i*W +: W]};
		vec_word = '0;
		for (int e = 0; e < fpr_pkg::VEC_N; e++)
			vec_word[(3-e)*W +: W] =
				front[(vec_base+4'(e))*W +: W];
	end

	// ----------------------------------------------------------------
	// Registered view outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mv_rdata_o     <= 64'h0000_0000_0000_0000;
			front_vector_o <= '0;
		end
		else
		begin
			mv_rdata_o     <= rd_word;
			front_vector_o <= vec_word;
		end
	end

	// Element (row r, column c) sits at slot 4c+r, so the flat word is
	// simply the back bank in slot order, one column after another.
	for (genvar k = 0; k < N; k++)
	begin : g_matrix
		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
				back_matrix_o[k*W +: W] <= 32'h0000_0000;
			else
				back_matrix_o[k*W +: W] <= back[k*W +: W];
		end
	end

	// ----------------------------------------------------------------
	// Instruction outcome pulses
	// ----------------------------------------------------------------
	logic [EW-1:0] enables;

	assign enables = sc_reg[fpr_pkg::ENABLE_LO +: EW];

	// The error source has no enable, so it always traps; the others trap
	// only when their enable bit is set.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			undefined_o <= 1'b0;
			exc_trap_o  <= 1'b0;
		end
		else
		begin
			undefined_o <= op_start_i && op_graphics_i && prec_o;
			exc_trap_o  <= new_exc[fpr_pkg::EXC_E] ||
				|(new_exc[EW-1:0] & enables);
		end
	end

endmodule

`default_nettype wire

// File: tb/fpr_core_chk.sv
// Port-level assertion checker for the register bank block.
`timescale 1ns/1ns
`default_nettype none

module fpr_core_chk (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Register loads and stores.
	input  wire logic        sc_wr_i,
	input  wire logic [31:0] sc_wdata_i,
	input  wire logic [31:0] sc_rdata_o,
	input  wire logic        xfer_wr_i,
	input  wire logic [31:0] xfer_wdata_i,
	input  wire logic [31:0] xfer_rdata_o,
	// Instruction events and results.
	input  wire logic        op_start_i,
	input  wire logic        op_graphics_i,
	input  wire logic        op_exc_valid_i,
	input  wire logic [5:0]  op_exc_i,
	input  wire logic        rnd_valid_i,
	input  wire logic        undefined_o,
	input  wire logic        exc_trap_o,
	// Mode slices.
	input  wire logic        prec_o,
	input  wire logic        pair_o,
	input  wire logic        dnrm_o,
	input  wire logic [1:0]  rnd_mode_o
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// A plain load is one with no instruction start, exception event or rounded result on the same edge.
	wire plain = !op_start_i && !op_exc_valid_i && !rnd_valid_i;

	AST_RSVD_ZERO: assert property (
		sc_rdata_o[31:22] == 10'h000)
		else $error("Reserved status bits read non-zero.");
	AST_SC_LOAD: assert property (
		sc_wr_i && plain |=>
		sc_rdata_o == ($past(sc_wdata_i) & fpr_pkg::SC_WMASK))
		else $error("Status load not stored as masked.");
	AST_MODE_VIEW: assert property (
		sc_wr_i && plain |=> {pair_o, prec_o, dnrm_o, rnd_mode_o} ==
		{$past(sc_wdata_i[20:18]), $past(sc_wdata_i[1:0])})
		else $error("Mode outputs do not follow the load.");
	AST_FLAG_STICKY: assert property (
		!sc_wr_i |=> (sc_rdata_o[6:2] & $past(sc_rdata_o[6:2]))
		== $past(sc_rdata_o[6:2]))
		else $error("Flag dropped without a load.");
	AST_CAUSE_CLEAR: assert property (
		op_start_i && !op_exc_valid_i && !rnd_valid_i && !sc_wr_i
		|=> sc_rdata_o[17:12] == 6'h00)
		else $error("Cause not cleared at instruction start.");
	AST_CAUSE_SET: assert property (
		op_exc_valid_i && !rnd_valid_i && !sc_wr_i |=>
		(sc_rdata_o[17:12] & $past(op_exc_i)) == $past(op_exc_i) &&
		(sc_rdata_o[6:2] & $past(op_exc_i[4:0])) == $past(op_exc_i[4:0]))
		else $error("Reported exception not recorded.");
	AST_TRAP: assert property (
		op_exc_valid_i && !rnd_valid_i && !sc_wr_i |=>
		exc_trap_o == ($past(op_exc_i[5]) ||
		($past(op_exc_i[4:0]) & $past(sc_rdata_o[11:7])) != 5'h00))
		else $error("Trap does not follow enables.");
	AST_TRAP_QUIET: assert property (
		!op_exc_valid_i && !rnd_valid_i |=> !exc_trap_o)
		else $error("Trap without an exception event.");
	AST_UNDEF: assert property (
		undefined_o == $past(op_start_i && op_graphics_i && prec_o))
		else $error("Undefined pulse wrong for graphics start.");
	AST_XFER: assert property (
		xfer_wr_i |=> xfer_rdata_o == $past(xfer_wdata_i))
		else $error("Transfer register not loaded.");
	AST_XFER_HOLD: assert property (
		!xfer_wr_i |=> $stable(xfer_rdata_o))
		else $error("Transfer register changed without a load.");

	COV_TRAP: cover property (op_exc_valid_i ##1 exc_trap_o);
	COV_UNDEF: cover property (undefined_o);
	COV_ROUND: cover property (rnd_valid_i && op_start_i);
endmodule

bind fpr_core fpr_core_chk fpr_core_chk_inst (.clk_i, .nrst_i, .sc_wr_i,
	.sc_wdata_i, .sc_rdata_o, .xfer_wr_i, .xfer_wdata_i, .xfer_rdata_o,
	.op_start_i, .op_graphics_i, .op_exc_valid_i, .op_exc_i, .rnd_valid_i,
	.undefined_o, .exc_trap_o, .prec_o, .pair_o, .dnrm_o, .rnd_mode_o);
`default_nettype wire

// File: tb/fpr_cpu_model.sv
// Integer core model that issues status/control loads as software does.
`timescale 1ns/1ns
`default_nettype none

module fpr_cpu_model (
	// Load request from the bench.
	input  wire logic        req_i,
	input  wire logic        raw_i,
	input  wire logic [31:0] data_i,
	// Load toward the block.
	output logic             sc_wr_o,
	output logic [31:0]      sc_wdata_o
);
	// ----------------------------------------------------------------
	// Software discipline
	// ----------------------------------------------------------------
	logic [31:0] clean;

	// Tidy the value; a raw load skips this to probe refusal.
	always_comb
	begin
		clean = data_i & fpr_pkg::SC_WMASK;
		if (clean[20])
			clean[19] = 1'b0;
		if (clean[1])
			clean[1:0] = 2'h1;
	end

	assign sc_wr_o    = req_i;
	assign sc_wdata_o = raw_i ? data_i : clean;
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the floating-point register bank block.
`timescale 1ns/1ns
`default_nettype none

module tb;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic         clk_i, nrst_i, sc_req, sc_raw, sc_wr, xfer_wr, mv_wr;
	logic         mv_wb, mv_rb, op_st, op_gr, op_ev, undef, trap, rnd_v;
	logic         rnd_sg, rnd_g, rnd_st, prec, pair, dnrm;
	logic [1:0]   vec_sel, rmode;
	logic [3:0]   mv_wi, mv_ri, rnd_dst;
	logic [4:0]   fl;
	logic [5:0]   op_ex, ex;
	logic [11:0]  rnd_e;
	logic [35:0]  c;
	logic [37:0]  e;
	logic [52:0]  rnd_s;
	logic [31:0]  sc_d, sc_wdata, sc_rdata, xfer_wd, xfer_rd, seed, r, q;
	logic [63:0]  mv_wd, mv_rd, got, dd;
	logic [127:0] fvec;
	logic [511:0] bmat;
	logic [31:0]  phys [32];
	int           n_mismatch, n_tests;

	// Rounding corners: mode, exponent, significand, guard, sticky.
	localparam logic [35:0] RCASE [7] = '{
		{1'b0, 9'h064, 24'h80_0001, 2'h2}, {1'b0, 9'h064, 24'h80_0002, 2'h2},
		{1'b0, 9'h0FE, 24'hFF_FFFF, 2'h2}, {1'b0, 9'h0FE, 24'hFF_FFFF, 2'h1},
		{1'b1, 9'h0FE, 24'hFF_FFFF, 2'h3}, {1'b1, 9'h0FF, 24'h80_0000, 2'h0},
		{1'b0, 9'h000, 24'h80_0000, 2'h0}};

	fpr_cpu_model fpr_cpu_model_inst (.req_i(sc_req), .raw_i(sc_raw),
		.data_i(sc_d), .sc_wr_o(sc_wr), .sc_wdata_o(sc_wdata));
	fpr_core fpr_core_inst (.clk_i(clk_i), .nrst_i(nrst_i), .sc_wr_i(sc_wr),
		.sc_wdata_i(sc_wdata), .sc_rdata_o(sc_rdata), .xfer_wr_i(xfer_wr),
		.xfer_wdata_i(xfer_wd), .xfer_rdata_o(xfer_rd), .mv_wr_i(mv_wr),
		.mv_wr_back_i(mv_wb), .mv_wr_idx_i(mv_wi), .mv_wdata_i(mv_wd),
		.mv_rd_back_i(mv_rb), .mv_rd_idx_i(mv_ri), .mv_rdata_o(mv_rd),
		.vec_sel_i(vec_sel), .front_vector_o(fvec), .back_matrix_o(bmat),
		.op_start_i(op_st), .op_graphics_i(op_gr), .op_exc_valid_i(op_ev),
		.op_exc_i(op_ex), .undefined_o(undef), .exc_trap_o(trap),
		.rnd_valid_i(rnd_v), .rnd_dst_i(rnd_dst), .rnd_sign_i(rnd_sg),
		.rnd_exp_i(rnd_e), .rnd_sig_i(rnd_s), .rnd_guard_i(rnd_g),
		.rnd_sticky_i(rnd_st), .prec_o(prec), .pair_o(pair), .dnrm_o(dnrm),
		.rnd_mode_o(rmode));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// Expected {cause, word}; single precision, flushing denormals.
	function automatic logic [37:0] rnd_ref(input logic [35:0] k,
		input logic sg);
		logic [24:0] m;
		logic [9:0]  x;
		if (k[34:26] == 9'h000)
			return {6'h03, sg, 31'h0};
		m = {1'b0, k[25:2]} + 25'(!k[35] && k[1] && (k[0] || k[2]));
		x = {1'b0, k[34:26]} + 10'(m[24]);
		if (x >= 10'h0FF)
			return {6'h05, sg, k[35] ? 31'h7F7F_FFFF : 31'h7F80_0000};
		return {5'h00, k[1] | k[0], sg, x[7:0], m[22:0]};
	endfunction

	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		n_tests++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic sc_w(input logic [31:0] v, input logic raw);
		@(posedge clk_i);
		sc_req <= 1'b1;
		sc_d <= v;
		sc_raw <= raw;
		@(posedge clk_i);
		sc_req <= 1'b0;
		sc_raw <= 1'b0;
		#1;
	endtask

	task automatic mv_w(input logic b, input logic [3:0] i,
		input logic [63:0] d);
		@(posedge clk_i);
		mv_wr <= 1'b1;
		mv_wb <= b;
		mv_wi <= i;
		mv_wd <= d;
		@(posedge clk_i);
		mv_wr <= 1'b0;
		#1;
	endtask

	// Selection is held, so waiting one extra edge is harmless.
	task automatic mv_r(input logic b, input logic [3:0] i);
		@(posedge clk_i);
		mv_rb <= b;
		mv_ri <= i;
		repeat (2) @(posedge clk_i);
		#1;
		got = mv_rd;
	endtask

	// Event strobes are raised for one edge together.
	task automatic pulse(input logic s, input logic gr, input logic [5:0] x);
		@(posedge clk_i);
		op_st <= s;
		op_gr <= gr;
		op_ev <= (x != 6'h00);
		op_ex <= x;
		@(posedge clk_i);
		{op_st, op_gr, op_ev} <= 3'h0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial
	begin
		#800000;
		n_mismatch++;
		end_of_test();
	end

	initial
	begin
		{nrst_i, sc_req, sc_raw, xfer_wr, mv_wr, mv_wb, mv_rb} = 7'h00;
		{op_st, op_gr, op_ev, rnd_v, rnd_sg, rnd_g, rnd_st} = 7'h00;
		{vec_sel, mv_wi, mv_ri, rnd_dst, op_ex, rnd_e, rnd_s} = '0;
		{sc_d, xfer_wd, mv_wd} = '0;
		{n_mismatch, n_tests} = '0;
		seed = 32'h0000_3494;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(sc_rdata, fpr_pkg::SC_RESET);
		for (int i = 0; i < 32; i++)
		begin
			phys[i] = lfsr();
			mv_w(i[4], i[3:0], {32'h0, phys[i]});
		end
		sc_w(32'h0024_0001, 1'b0);
		for (int i = 0; i < 32; i++)
		begin
			mv_r(i[4], i[3:0]);
			chk(got, {32'h0, phys[i ^ 16]});
		end
		sc_w(32'h0034_0001, 1'b0);
		dd = {lfsr(), lfsr()};
		mv_w(1'b0, 4'h5, dd);
		{phys[20], phys[21]} = dd;
		for (int i = 0; i < 32; i += 2)
		begin
			mv_r(i[4], i[3:0]);
			chk(got, {phys[i ^ 16], phys[(i ^ 16) + 1]});
		end
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk_i);
			vec_sel <= s[1:0];
			repeat (2) @(posedge clk_i);
			#1;
			chk(fvec[127:64], {phys[16 + 4 * s], phys[17 + 4 * s]});
			chk(fvec[63:0], {phys[18 + 4 * s], phys[19 + 4 * s]});
		end
		for (int k = 0; k < 16; k++)
			chk({32'h0, bmat[k * 32 +: 32]}, {32'h0, phys[k]});
		// A mode load and a pair move on one edge: the move sees old modes.
		dd = {lfsr(), lfsr()};
		@(posedge clk_i);
		{sc_req, mv_wr, mv_wb, mv_wi} <= {3'h6, 4'h3};
		sc_d <= 32'h0004_0001;
		mv_wd <= dd;
		@(posedge clk_i);
		{sc_req, mv_wr} <= 2'h0;
		{phys[18], phys[19]} = dd;
		for (int j = 2; j < 4; j++)
		begin
			mv_r(1'b1, j[3:0]);
			chk(got, {32'h0, phys[16 + j]});
		end
		mv_r(1'b0, 4'h3);
		chk(got, {32'h0, phys[3]});
		for (int i = 0; i < 4; i++)
		begin
			dd[31:0] = lfsr();
			@(posedge clk_i);
			xfer_wr <= 1'b1;
			xfer_wd <= dd[31:0];
			@(posedge clk_i);
			xfer_wr <= 1'b0;
			#1;
			chk({32'h0, xfer_rd}, {32'h0, dd[31:0]});
		end
		// Rounding: corner table first, then random operands.
		for (int i = 0; i < 23; i++)
		begin
			r = lfsr();
			q = lfsr();
			c = (i < 7) ? RCASE[i] :
				{r[31], 1'b0, r[7:0] | 8'h01, 1'b1, q[22:0], q[31:30]};
			e = rnd_ref(c, r[30]);
			sc_w({31'h0002_0000, c[35]}, 1'b0);
			@(posedge clk_i);
			{rnd_v, op_st, rnd_sg, rnd_g, rnd_st} <= {3'h6 | r[30], c[0], c[0]};
			{rnd_dst, rnd_e} <= {4'h7, 3'h0, c[34:26]};
			rnd_s <= {c[25:1], 28'h0};
			@(posedge clk_i);
			{rnd_v, op_st} <= 2'h0;
			#1;
			chk(sc_rdata[17:12], e[37:32]);
			mv_r(1'b0, 4'h7);
			chk(got, {32'h0, e[31:0]});
		end
		// Double precision: a nearest-mode carry past the top gives infinity.
		sc_w(32'h0008_0000, 1'b0);
		@(posedge clk_i);
		{rnd_v, op_st, rnd_sg, rnd_g, rnd_st} <= 5'h1A;
		{rnd_dst, rnd_e, rnd_s} <= {4'h6, 12'h7FE, {53{1'b1}}};
		@(posedge clk_i);
		{rnd_v, op_st} <= 2'h0;
		#1;
		chk(sc_rdata[17:12], 6'h05);
		sc_w(32'h0010_0001, 1'b0);
		chk({pair, prec, dnrm, rmode}, 5'h11);
		mv_r(1'b0, 4'h6);
		chk(got, 64'h7FF0_0000_0000_0000);
		sc_w(32'h0004_0A81, 1'b0);
		fl = 5'h00;
		for (int b = 0; b < 6; b++)
		begin
			ex = 6'h01 << b;
			fl = fl | ex[4:0];
			pulse(1'b1, 1'b0, ex);
			chk(sc_rdata[17:12], ex);
			chk(sc_rdata[6:2], fl);
			chk(trap, ex[5] || (ex[4:0] & 5'h15) != 5'h00);
		end
		pulse(1'b1, 1'b0, 6'h00);
		chk(sc_rdata[17:2], 16'h02BF);
		for (int p = 0; p < 2; p++)
		begin
			sc_w(32'h0004_0001 | (32'(p) << 19), 1'b0);
			pulse(1'b1, 1'b1, 6'h00);
			chk(undef, p[0]);
			chk({prec, dnrm, rmode}, {p[0], 3'h5});
		end
		sc_w(32'hFFC4_0001, 1'b1);
		chk(sc_rdata, 32'h0004_0001);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({xfer_rd, sc_rdata}, {32'h0, fpr_pkg::SC_RESET});
		end_of_test();
	end
endmodule
`default_nettype wire
